//--- pkg/sois_pkg.sv
// constants for the output interpolation and scaling stage of the pressure chain
// assumes one 100 MHz clock; all codes are two's complement where signed
package sois_pkg;
   // clock period and chain sample period (the sample period is a plain default)
   localparam int CLK_NS = 10;
   localparam int SAMPLE_NS = 8000;
   // interpolation steps per sample period and the width of the step index
   localparam int STEPS = 16;
   localparam int STEP_W = 4;
   // cycles per interpolation step, derived from the sample period
   localparam int SUB_CYCLES = SAMPLE_NS / CLK_NS / STEPS;
   localparam int DATA_W = 16;
   // calibration value for which the listed encodings hold
   localparam logic [15:0] CAL_ZERO_NONE = 16'h0000;
   // absolute pressure: 16-bit words carry 28672 at zero, 57.5 per kPa
   localparam logic [15:0] ABS16_OFF = 16'h7000;
   localparam int ABS12_SHIFT = 1;   // 28.75 per kPa, zero offset
   localparam int ABS10_SHIFT = 3;   // 7.188 per kPa, zero offset
   // relative pressure: 240 codes per percent, so 24000 per unit ratio
   localparam logic [15:0] REL16_ZERO = 16'h75c0;
   localparam logic signed [15:0] REL16_GAIN = 16'sh5dc0;
   localparam logic [11:0] REL12_ZERO = 12'h2e0;
   localparam int REL12_SHIFT = 1;   // 120 per percent
   localparam logic [9:0] REL10D_ZERO = 10'h0b8;
   localparam logic [9:0] REL10P_ZERO = 10'h2b8;   // -328
   localparam int REL10_SHIFT = 3;   // 30 per percent
   // temperature: 16-bit words carry 17408 at 0 C, 256 per degree
   localparam logic [15:0] TEMP16_ZERO = 16'h4400;
   localparam logic [7:0] TEMP8_ZERO = 8'h44;
   localparam int TEMP8_SHIFT = 8;
   localparam logic [11:0] TEMP12_ZERO = 12'h440;
   localparam int TEMP12_SHIFT = 4;
   localparam logic [9:0] TEMP10D_ZERO = 10'h110;
   localparam int TEMP10D_SHIFT = 6;
   localparam logic [9:0] TEMP10P_ZERO = 10'h3e5;   // -27
   localparam int TEMP10P_SHIFT = 8;
endpackage

//--- src/sois_interp.sv
// 16-to-1 linear interpolator between two successive chain results
// assumes newValid is a one-cycle pulse and stepTick a one-cycle enable
`timescale 1ns/1ps
module sois_interp
   import sois_pkg::*;
#(
   parameter int W = DATA_W
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic newValid,
   input wire logic [W-1:0] newResult,
   input wire logic stepTick,
   output logic outValid,
   output logic [W-1:0] outValue,
   output logic [sois_pkg::STEP_W-1:0] stepIndex
);
   import sois_pkg::*;

   // all state of the interpolator
   typedef struct packed {
      logic [W-1:0] cur;          // held target result
      logic [W-1:0] out;          // current interpolated value
      logic [STEP_W-1:0] idx;     // step index within the period
      logic primed;               // a previous result exists
      logic valid;                // one-cycle pulse per new output
   } sois_interp_s;

   sois_interp_s s_q, s_d;
   logic signed [W:0] diff;       // target minus prior output
   logic signed [W:0] stepV;      // one step increment
   logic [STEP_W+1:0] divisor;    // 16 - (i-1) for step i = idx+1

   // next-state logic
   always_comb begin
      s_d = s_q;
      s_d.valid = 1'b0;
      divisor = (STEP_W+2)'(STEPS) - (STEP_W+2)'(s_q.idx);
      diff = $signed({1'b0, s_q.cur}) - $signed({1'b0, s_q.out});
      stepV = diff / $signed({1'b0, divisor});
      if (newValid) begin
         // (RQ2) hold one period
         // (RQ4) step zero is previous result
         s_d.out = s_q.cur;
         s_d.cur = newResult;
         // (RQ5) restart index on result
         s_d.idx = '0;
         s_d.primed = 1'b1;
         s_d.valid = s_q.primed;
      end else if (stepTick && s_q.primed && s_q.idx != STEP_W'(STEPS - 1)) begin
         // (RQ5) advance once per step
         s_d.idx = s_q.idx + STEP_W'(1);
         // (RQ4) move toward current result
         // (RQ3) formed from two results
         s_d.out = s_q.out + stepV[W-1:0];
         // (RQ1) sixteen outputs per period
         s_d.valid = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign outValid = s_q.valid;
   assign outValue = s_q.out;
   assign stepIndex = s_q.idx;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // a new result enters and is seen as the target a cycle later
   sequence newArrives;
      newValid ##1 1'b1;
   endsequence

   a_first_previous: assert property ( // RQ4
      newValid |=> (outValue == $past(s_q.cur)) && (stepIndex == '0))
      else $error("first interpolated value is not the previous result");
   a_target_held: assert property ( // RQ2
      newArrives |-> s_q.cur == $past(newResult))
      else $error("new result not held as target");
   a_index_step: assert property ( // RQ5
      (stepTick && !newValid && s_q.primed && stepIndex != 4'hf)
      |=> stepIndex == $past(stepIndex) + 4'h1)
      else $error("step index did not advance");
   a_index_hold: assert property ( // RQ1
      (!stepTick && !newValid) |=> $stable(stepIndex) && $stable(outValue))
      else $error("output moved without a step");
   // last step divides the remaining distance by two, worked out independently
   a_last_step: assert property ( // RQ3
      (stepTick && !newValid && stepIndex == 4'he)
      |=> $signed({1'b0, outValue}) == $signed({1'b0, $past(outValue)})
          + ($signed({1'b0, $past(s_q.cur)}) - $signed({1'b0, $past(outValue)})) / 17'sd2
          && stepIndex == 4'hf)
      else $error("last step wrong");
endmodule

//--- src/sois_top.sv
// output stage: interpolation of chain results and scaling to every output width
// assumes chainValid pulses once per sample period with synchronous data
`timescale 1ns/1ps

// Notes on behaviour
// (RQ1) sixteen interpolated outputs per sample period
// (RQ2) each new result delayed one period
// (RQ3) output from last two results only
// (RQ4) step zero previous; later steps divide remainder
// (RQ5) step index advances per sixteenth, restarts
// (RQ6) 16-bit register absolute: 28672, 57.5/kPa
// (RQ7) 16-bit periodic absolute same encoding
// (RQ8) 12-bit absolute: zero offset, 28.75/kPa
// (RQ9) 10-bit absolute: zero offset, 7.188/kPa
// (RQ10) calibration value: zero offset, 57.5/kPa
// (RQ11) nonzero calibration shifts reported codes
// (RQ12) 16-bit relative: 30144, 240 per percent
// (RQ13) 12-bit relative: 736, 120 per percent
// (RQ14) 10-bit relative: 30/%, 184 or -328
// (RQ15) temperature 8-bit 68/1, 16-bit 17408/256
// (RQ16) temperature 12/10-bit periodic and ten-bit sensor
// (RQ17) relative is (abs minus reference) over reference
module sois_top
   import sois_pkg::*;
#(
   parameter int SUB_CNT = SUB_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic chainValid,
   input wire logic [sois_pkg::DATA_W-1:0] chainResult,
   input wire logic [15:0] ambientReference,
   input wire logic [15:0] calZero,
   input wire logic [15:0] tempRaw,
   output logic dataValid,
   output logic [15:0] absPressure16,
   output logic [11:0] absPressure12,
   output logic [9:0] absPressure10,
   output logic [15:0] relPressure16,
   output logic [11:0] relPressure12,
   output logic [9:0] relPressure10Dsi,
   output logic [9:0] relPressure10Psi,
   output logic [7:0] temp8,
   output logic [15:0] temp16,
   output logic [11:0] temp12,
   output logic [9:0] temp10Dsi,
   output logic [9:0] temp10Psi
);
   import sois_pkg::*;

   // all state of the stage outside the interpolator
   typedef struct packed {
      logic [15:0] divCnt;        // cycles within one step
      logic tick;                 // one-cycle step enable
      logic valid;                // new scaled words present
      logic [15:0] abs16;
      logic [11:0] abs12;
      logic [9:0] abs10;
      logic [15:0] rel16;
      logic [11:0] rel12;
      logic [9:0] rel10d;
      logic [9:0] rel10p;
      logic [7:0] t8;
      logic [15:0] t16;
      logic [11:0] t12;
      logic [9:0] t10d;
      logic [9:0] t10p;
   } sois_top_s;

   sois_top_s s_q, s_d;
   logic interpValid;             // interpolator produced a value
   logic [DATA_W-1:0] interpOut;  // interpolated absolute word
   logic signed [16:0] absCorr;   // word after calibration shift
   logic signed [17:0] absZero;   // zero-offset absolute code
   logic signed [17:0] pDiff;     // absolute minus reference
   logic signed [35:0] pNum;      // difference scaled to relative codes
   logic signed [35:0] pRatio;    // relative deviation in 16-bit codes
   logic signed [16:0] relDev;    // relative deviation, truncated to 17 bits
   logic signed [16:0] tDev;      // temperature deviation from 0 C

   // arithmetic right shift of a signed deviation
   function automatic logic signed [17:0] dev_shift(input logic signed [17:0] v, input int n);
      dev_shift = v >>> n;
   endfunction

   // interpolator between the two latest chain results
   sois_interp #(
      .W(DATA_W)
   ) u_interp (
      .clock(clock),
      .rst_n(rst_n),
      .newValid(chainValid),
      .newResult(chainResult),
      .stepTick(s_q.tick),
      .outValid(interpValid),
      .outValue(interpOut),
      .stepIndex()
   );

   // datapath for the scaled words
   always_comb begin
      // (RQ11) calibration shifts codes
      // (RQ10) calibration has zero offset
      absCorr = $signed({1'b0, interpOut}) - $signed({1'b0, calZero});
      absZero = 18'(absCorr) - $signed({2'b00, ABS16_OFF});
      // (RQ17) relative from reference
      pDiff = absZero - $signed({2'b00, ambientReference});
      pNum = 36'(pDiff) * 36'(REL16_GAIN);
      pRatio = (ambientReference == 16'h0000) ? 36'sh0 :
         pNum / $signed({20'h00000, ambientReference});
      relDev = pRatio[16:0];
      tDev = $signed({1'b0, tempRaw}) - $signed({1'b0, TEMP16_ZERO});
   end

   // next-state logic
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      s_d.valid = 1'b0;
      // (RQ5) step divider restarts on results
      if (chainValid || s_q.divCnt == 16'(SUB_CNT - 1)) begin
         s_d.divCnt = '0;
         s_d.tick = !chainValid;
      end else begin
         s_d.divCnt = s_q.divCnt + 16'h0001;
      end
      if (interpValid) begin
         s_d.valid = 1'b1;
         // (RQ6) register absolute word
         // (RQ7) periodic word identical
         s_d.abs16 = absCorr[15:0];
         // (RQ8) half the 16-bit sensitivity
         s_d.abs12 = 12'(dev_shift(absZero, ABS12_SHIFT));
         // (RQ9) eighth of 16-bit sensitivity
         s_d.abs10 = 10'(dev_shift(absZero, ABS10_SHIFT));
         // (RQ12) relative 16-bit word
         s_d.rel16 = REL16_ZERO + relDev[15:0];
         // (RQ13) relative 12-bit word
         s_d.rel12 = REL12_ZERO + 12'(dev_shift(18'(relDev), REL12_SHIFT));
         // (RQ14) two ten-bit relative offsets
         s_d.rel10d = REL10D_ZERO + 10'(dev_shift(18'(relDev), REL10_SHIFT));
         s_d.rel10p = REL10P_ZERO + 10'(dev_shift(18'(relDev), REL10_SHIFT));
      end
      // (RQ15) eight and sixteen bit temperature
      s_d.t16 = tempRaw;
      s_d.t8 = TEMP8_ZERO + 8'(dev_shift(18'(tDev), TEMP8_SHIFT));
      // (RQ16) narrower temperature words
      s_d.t12 = TEMP12_ZERO + 12'(dev_shift(18'(tDev), TEMP12_SHIFT));
      s_d.t10d = TEMP10D_ZERO + 10'(dev_shift(18'(tDev), TEMP10D_SHIFT));
      s_d.t10p = TEMP10P_ZERO + 10'(dev_shift(18'(tDev), TEMP10P_SHIFT));
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign dataValid = s_q.valid;
   assign absPressure16 = s_q.abs16;
   assign absPressure12 = s_q.abs12;
   assign absPressure10 = s_q.abs10;
   assign relPressure16 = s_q.rel16;
   assign relPressure12 = s_q.rel12;
   assign relPressure10Dsi = s_q.rel10d;
   assign relPressure10Psi = s_q.rel10p;
   assign temp8 = s_q.t8;
   assign temp16 = s_q.t16;
   assign temp12 = s_q.t12;
   assign temp10Dsi = s_q.t10d;
   assign temp10Psi = s_q.t10p;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_abs_pass: assert property ( // RQ6
      (interpValid && calZero == CAL_ZERO_NONE) |=> absPressure16 == $past(interpOut))
      else $error("16-bit absolute word differs from interpolated value");
   a_abs_narrow: assert property ( // RQ8
      (interpValid && interpOut == 16'h7000 && calZero == CAL_ZERO_NONE)
      |=> absPressure12 == 12'h000 && absPressure10 == 10'h000)
      else $error("narrow absolute words not zero at zero pressure");
   a_cal_shift: assert property ( // RQ11
      (interpValid && calZero != CAL_ZERO_NONE)
      |=> absPressure16 == $past(interpOut) - $past(calZero))
      else $error("calibration shift missing");
   a_rel_const: assert property ( // RQ12
      (interpValid && calZero == CAL_ZERO_NONE && ambientReference != 16'h0000
       && interpOut == ambientReference + 16'h7000)
      |=> relPressure16 == 16'h75c0 && relPressure12 == 12'h2e0
          && relPressure10Dsi == 10'h0b8 && relPressure10Psi == 10'h2b8)
      else $error("relative words wrong at constant pressure");
   a_rel_psi: assert property ( // RQ14
      dataValid |-> relPressure10Psi == relPressure10Dsi + 10'h200)
      else $error("ten-bit relative offsets inconsistent");
   a_temp_zero: assert property ( // RQ15
      tempRaw == 16'h4400 |=> temp8 == 8'h44 && temp16 == 16'h4400
          && temp12 == 12'h440 && temp10Dsi == 10'h110 && temp10Psi == 10'h3e5)
      else $error("temperature words wrong at zero degrees");
   a_temp_step: assert property ( // RQ16
      tempRaw == 16'h4500 |=> temp12 == 12'h450 && temp10Dsi == 10'h114
          && temp10Psi == 10'h3e6 && temp8 == 8'h45)
      else $error("temperature sensitivity wrong");
   a_tick_spacing: assert property ( // RQ5
      (s_q.tick && !chainValid) |=> !s_q.tick)
      else $error("step enable too frequent");
endmodule

//--- dv/sois_chain_src.sv
// partner model: the processing chain that hands results to the output stage
// assumes the bench raises fire for one falling edge per result
`timescale 1ns/1ps
module sois_chain_src (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic fire,
   input wire logic [15:0] fireVal,
   output logic chainValid,
   output logic [15:0] chainResult
);
   // result word is valid only with its pulse; otherwise it shows a scrambled value
   always_ff @(negedge clock or negedge rst_n) begin
      if (!rst_n) begin
         chainValid <= 1'b0;
         chainResult <= 16'h5a5a;
      end else begin
         chainValid <= fire;
         chainResult <= fire ? fireVal : ~chainResult;
      end
   end
endmodule

//--- dv/sensor_output_interpolation_scaling_bench.sv
// self-checking bench for the output interpolation and scaling stage
// assumes a short step divider (SUB_CNT 4) so a sample period is 64 cycles
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module sensor_output_interpolation_scaling_bench;
   // encoding constants of the output words
   localparam int AOFF = 32'sh7000;
   localparam int REF = 32'sh1676;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic fire = 1'b0;
   logic [15:0] fireVal = 16'h0000;
   logic chainValid, dataValid;
   logic [15:0] chainResult, absPressure16, relPressure16, temp16;
   logic [15:0] ambientReference = 16'h1676;
   logic [15:0] calZero = 16'h0000;
   logic [15:0] tempRaw = 16'h4400;
   logic [11:0] absPressure12, relPressure12, temp12;
   logic [9:0] absPressure10, relPressure10Dsi, relPressure10Psi, temp10Dsi, temp10Psi;
   logic [7:0] temp8;
   int error_cnt = 0;
   int compares = 0;
   int last;
   // 100 MHz clock
   always #5 clock = ~clock;
   sois_chain_src u_src (.clock(clock), .rst_n(rst_n), .fire(fire), .fireVal(fireVal),
      .chainValid(chainValid), .chainResult(chainResult));
   sois_top #(.SUB_CNT(4)) u_dut (.clock(clock), .rst_n(rst_n), .chainValid(chainValid),
      .chainResult(chainResult), .ambientReference(ambientReference), .calZero(calZero),
      .tempRaw(tempRaw), .dataValid(dataValid), .absPressure16(absPressure16),
      .absPressure12(absPressure12), .absPressure10(absPressure10),
      .relPressure16(relPressure16), .relPressure12(relPressure12),
      .relPressure10Dsi(relPressure10Dsi), .relPressure10Psi(relPressure10Psi),
      .temp8(temp8), .temp16(temp16), .temp12(temp12), .temp10Dsi(temp10Dsi),
      .temp10Psi(temp10Psi));
   // verdict and end of run
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one chain result, pulsed through the partner model
   task automatic send(input logic [15:0] v);
      @(negedge clock);
      fire <= 1'b1;
      fireVal <= v;
      @(negedge clock);
      fire <= 1'b0;
   endtask
   // bounded wait for the next output pulse
   task automatic waitv();
      int n;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (dataValid !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         final_report();
      end
   endtask
   // absolute words for one interpolated value
   task automatic chk_abs(input int w, input int cz);
      `CHK(absPressure16, 16'(w - cz))
      `CHK(absPressure12, 12'((w - AOFF - cz) >>> 1))
      `CHK(absPressure10, 10'((w - AOFF - cz) >>> 3))
   endtask
   // relative words for the value held now
   task automatic chk_rel(input int w, input int cz);
      int dev;
      dev = ((w - AOFF - cz - REF) * 24000) / REF;
      `CHK(relPressure16, 16'(30144 + dev))
      `CHK(relPressure12, 12'(736 + (dev >>> 1)))
      `CHK(relPressure10Dsi, 10'(184 + (dev >>> 3)))
      `CHK(relPressure10Psi, 10'(-328 + (dev >>> 3)))
   endtask
   // sixteen steps from prev toward cur after the result just sent
   task automatic walk(input int prev, input int cur, input int cz, output int fin);
      int out;
      out = prev;
      repeat (2) @(negedge clock);
      `CHK(dataValid, 1'b1)
      for (int i = 0; i < 16; i++) begin
         if (i > 0) begin
            waitv();
            out = out + (cur - out) / (17 - i);
         end
         chk_abs(out, cz);
      end
      fin = out;
   endtask
   // two results a period apart give sixteen outputs; step eight crosses zero pressure
   task automatic test_interp();
      send(16'h6c00);
      repeat (62) @(negedge clock);
      send(16'h7400);
      walk(32'sh6c00, 32'sh7400, 0, last);
      chk_rel(last, 0);
      $display("test interp done");
   endtask
   // early result restarts the period; steady value at the reference gives constant words
   task automatic test_restart();
      send(16'h8676);
      repeat (10) @(negedge clock);
      send(16'h8676);
      walk(32'sh8676, 32'sh8676, 0, last);
      chk_rel(last, 0);
      $display("test restart done");
   endtask
   // nonzero calibration shifts every pressure word
   task automatic test_cal();
      calZero <= 16'h0100;
      send(16'h8908);
      walk(32'sh8676, 32'sh8908, 32'sh100, last);
      chk_rel(last, 32'sh100);
      $display("test cal done");
   endtask
   // temperature words over a small table
   task automatic test_temp();
      int d;
      logic [15:0] tv[4];
      tv = '{16'h4400, 16'h4d40, 16'h3000, 16'h4500};
      foreach (tv[k]) begin
         @(negedge clock);
         tempRaw <= tv[k];
         repeat (2) @(negedge clock);
         d = int'(tv[k]) - 32'sh4400;
         `CHK(temp8, 8'(68 + (d >>> 8)))
         `CHK(temp16, tv[k])
         `CHK(temp12, 12'(1088 + (d >>> 4)))
         `CHK(temp10Dsi, 10'(272 + (d >>> 6)))
         `CHK(temp10Psi, 10'(-27 + (d >>> 8)))
      end
      $display("test temp done");
   endtask
   // main sequence
   initial begin
      repeat (12) @(negedge clock);
      rst_n <= 1'b1;
      test_interp();
      test_restart();
      test_temp();
      test_cal();
      final_report();
   end
endmodule
